/* File: hw/mcec_unit.sv */
// positioning unit end: validates commands and writes, latches error codes
`timescale 1ns/1ps
module mcec_unit #(
   parameter logic [6:0] MAX_WORDS = mcec_pkg::WR_MAX_WORDS
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   // link to host
   mcec_link_if.unit link,
   // axis and data state from the motion core
   input wire logic i_x_moving,
   input wire logic i_y_moving,
   input wire logic i_interp_busy,
   input wire logic i_origin_set,
   input wire logic i_speed_zero,
   input wire logic i_stroke_over,
   input wire logic i_blk_is_interp,
   input wire logic i_blk_axis_dis,
   input wire logic i_arc_same_end,
   input wire logic i_arc_no_end,
   // serial peripheral fault pins
   input wire logic i_ser_parity_fail,
   input wire logic i_ser_frame_fail,
   input wire logic i_ser_overrun,
   // accepted request to the motion core: one-cycle pulses, opcode held until the next
   output logic o_exec,
   output logic [3:0] o_exec_op,
   output logic o_write_exec
);
   typedef struct packed {
      mcec_pkg::mcec_state_t st;
      logic [7:0] code;
      logic [7:0] status;
      logic latched;
      logic ack;
      logic exec;
      logic [3:0] exec_op;
      logic write_exec;
      logic is_write;
      logic [3:0] op;
      logic [2:0] cnt;
      logic [7:0] opnd;
      logic fmt_ok;
      logic [15:0] addr;
      logic [7:0] words;
      logic [15:0] len;
      logic data_ok;
      logic wfmt_ok;
   } mcec_unit_t;
   mcec_unit_t q, d;
   logic ser_fault;
   logic [7:0] ser_code;
   logic moving;
   logic [7:0] chk;
   mcec_serial_mon u_ser (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_ce(i_ce),
      .i_parity_fail(i_ser_parity_fail),
      .i_frame_fail(i_ser_frame_fail),
      .i_overrun(i_ser_overrun),
      .o_fault(ser_fault),
      .o_code(ser_code)
   );
   // either axis in motion blocks writes and stopped-only commands
   assign moving = i_x_moving | i_y_moving;

   // check a captured command in priority order
   // motion and block inputs are read in the check cycle, not at the take edge
   always_comb
   begin
      chk = mcec_pkg::ERR_NONE;
      // write checks: word count first, so an oversize block never reaches the rest
      if (q.is_write)
      begin
         if (q.words > {1'b0, MAX_WORDS})
            chk = mcec_pkg::ERR_WORD_COUNT;
         else if (moving)
            chk = mcec_pkg::ERR_WR_MOVING;
         else if (q.addr >= mcec_pkg::WR_ADDR_LIMIT)
            chk = mcec_pkg::ERR_WR_ADDR;
         else if (q.len == 16'h0000 || q.len > {8'h00, q.words})
            chk = mcec_pkg::ERR_WR_LEN;
         else if (!q.data_ok)
            chk = mcec_pkg::ERR_WR_VALUE;
         else if (!q.wfmt_ok)
            chk = mcec_pkg::ERR_WR_FMT;
      end
      else if (q.op == 4'h0 || q.op > mcec_pkg::OP_LAST)
         chk = mcec_pkg::ERR_OPCODE;
      else if (q.cnt != mcec_pkg::mcec_opnd_need(q.op))
         chk = mcec_pkg::ERR_OPND_COUNT;
      else if (q.cnt != 3'h0 && q.opnd > mcec_pkg::OPND_MAX)
         chk = mcec_pkg::ERR_OPND_UNDEF;
      else if (q.cnt != 3'h0 && !q.fmt_ok)
         chk = mcec_pkg::ERR_OPND_FMT;
      else if (i_interp_busy && mcec_pkg::mcec_single_axis(q.op))
         chk = mcec_pkg::ERR_INTERP_BUSY;
      else if (moving && q.op != mcec_pkg::OP_STOP && q.op != mcec_pkg::OP_ERROR_RESET)
         chk = mcec_pkg::ERR_TIMING;
      // block data checks only for interpolation start
      else if (q.op == mcec_pkg::OP_INTERP_START)
      begin
         if (!i_blk_is_interp)
            chk = mcec_pkg::ERR_NOT_INTERP;
         else if (i_blk_axis_dis)
            chk = mcec_pkg::ERR_AXIS_DIS;
         else if (i_arc_same_end)
            chk = mcec_pkg::ERR_ARC_SAME;
         else if (i_arc_no_end)
            chk = mcec_pkg::ERR_ARC_NOEND;
         else if (i_stroke_over)
            chk = mcec_pkg::ERR_STROKE;
      end
      else if ((q.op == mcec_pkg::OP_X_AXIS_START || q.op == mcec_pkg::OP_Y_AXIS_START) &&
         i_stroke_over)
         chk = mcec_pkg::ERR_STROKE;
      else if ((q.op == mcec_pkg::OP_POSITION_START || q.op == mcec_pkg::OP_ORIGIN_SEARCH ||
         q.op == mcec_pkg::OP_MANUAL_JOG) && i_speed_zero)
         chk = mcec_pkg::ERR_SPEED0;
      else if (q.op == mcec_pkg::OP_POSITION_START && !i_origin_set)
         chk = mcec_pkg::ERR_NO_ORIGIN;
   end

   // request capture, check, answer and error latch
   always_comb
   begin
      d = q;
      d.ack = 1'b0;
      d.exec = 1'b0;
      d.write_exec = 1'b0;
      case (q.st)
         mcec_pkg::MCEC_IDLE:
         begin
            // capture every field; the kind decides which ones are checked
            if (link.req_valid)
            begin
               d.is_write = (link.req_kind == mcec_pkg::MCEC_REQ_WRITE);
               d.op = link.cmd_op;
               d.cnt = link.cmd_opnd_cnt;
               d.opnd = link.cmd_opnd;
               d.fmt_ok = link.cmd_opnd_fmt_ok;
               d.addr = link.wr_addr;
               d.words = link.wr_words;
               d.len = link.wr_len;
               d.data_ok = link.wr_data_ok;
               d.wfmt_ok = link.wr_fmt_ok;
               d.st = mcec_pkg::MCEC_CHECK;
            end
         end
         mcec_pkg::MCEC_CHECK:
         begin
            d.code = chk;
            d.ack = 1'b1;
            // nothing reaches the motion core while chk holds an error
            if (chk != mcec_pkg::ERR_NONE)
            begin
               d.status = chk;
               d.latched = 1'b1;
            end
            else if (!q.is_write && q.op == mcec_pkg::OP_ERROR_RESET)
            begin
               d.status = mcec_pkg::ERR_NONE;
               d.latched = 1'b0;
            end
            else if (q.is_write)
               d.write_exec = 1'b1;
            else
            begin
               d.exec = 1'b1;
               d.exec_op = q.op;
            end
            d.st = mcec_pkg::MCEC_ANSWER;
         end
         // one busy cycle lets the host drop its request before ready returns
         mcec_pkg::MCEC_ANSWER:
            d.st = mcec_pkg::MCEC_IDLE;
         default:
            d.st = mcec_pkg::MCEC_IDLE;
      endcase
      // serial faults latch on their own and win over a reset in the same cycle
      if (ser_fault)
      begin
         d.status = ser_code;
         d.latched = 1'b1;
      end
   end
   // state register
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
         q <= '0;
      else if (i_ce)
         q <= d;
   end

   // ready follows the idle state only
   assign link.req_ready = (q.st == mcec_pkg::MCEC_IDLE);
   // answer and latched status straight from the state register
   assign link.ack_valid = q.ack;
   assign link.ack_code = q.code;
   assign link.status_code = q.status;
   assign link.err_latched = q.latched;
   // execution pulses and opcode for the motion core
   assign o_exec = q.exec;
   assign o_exec_op = q.exec_op;
   assign o_write_exec = q.write_exec;
endmodule : mcec_unit

/* File: hw/mcec_pkg.sv */
// constants and types shared by both ends of the command error checker
package mcec_pkg;
   // opcodes
   localparam logic [3:0] OP_POSITION_START = 4'h1;
   localparam logic [3:0] OP_X_AXIS_START = 4'h2;
   localparam logic [3:0] OP_Y_AXIS_START = 4'h3;
   localparam logic [3:0] OP_INTERP_START = 4'h4;
   localparam logic [3:0] OP_ORIGIN_SEARCH = 4'h5;
   localparam logic [3:0] OP_MANUAL_JOG = 4'h6;
   localparam logic [3:0] OP_ERROR_RESET = 4'h7;
   localparam logic [3:0] OP_STOP = 4'h8;
   localparam logic [3:0] OP_LAST = 4'h8;
   // operand fields
   localparam logic [7:0] OPND_MAX = 8'h63;
   localparam logic [1:0] AXIS_X = 2'h1;
   localparam logic [1:0] AXIS_Y = 2'h2;
   localparam logic [1:0] AXIS_XY = 2'h3;
   // write limits
   localparam logic [6:0] WR_MAX_WORDS = 7'h7F;
   localparam logic [15:0] WR_ADDR_LIMIT = 16'h0400;
   localparam logic [15:0] WR_DATA_LIMIT = 16'h9999;
   // error codes, decimal figures as printed
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_OPCODE = 8'd30;
   localparam logic [7:0] ERR_OPND_COUNT = 8'd31;
   localparam logic [7:0] ERR_TIMING = 8'd32;
   localparam logic [7:0] ERR_INTERP_BUSY = 8'd33;
   localparam logic [7:0] ERR_OPND_UNDEF = 8'd40;
   localparam logic [7:0] ERR_OPND_FMT = 8'd41;
   localparam logic [7:0] ERR_NOT_INTERP = 8'd50;
   localparam logic [7:0] ERR_AXIS_DIS = 8'd51;
   localparam logic [7:0] ERR_ARC_SAME = 8'd52;
   localparam logic [7:0] ERR_ARC_NOEND = 8'd53;
   localparam logic [7:0] ERR_WR_ADDR = 8'd54;
   localparam logic [7:0] ERR_WR_LEN = 8'd55;
   localparam logic [7:0] ERR_WR_MOVING = 8'd56;
   localparam logic [7:0] ERR_WR_VALUE = 8'd57;
   localparam logic [7:0] ERR_WR_FMT = 8'd58;
   localparam logic [7:0] ERR_STROKE = 8'd59;
   localparam logic [7:0] ERR_SPEED0 = 8'd60;
   localparam logic [7:0] ERR_NO_ORIGIN = 8'd61;
   localparam logic [7:0] ERR_PARITY = 8'd70;
   localparam logic [7:0] ERR_FRAMING = 8'd71;
   localparam logic [7:0] ERR_OVERRUN = 8'd72;
   localparam logic [7:0] ERR_WORD_COUNT = 8'd80;
   // request kinds on the link
   typedef enum logic [1:0] {MCEC_REQ_CMD = 2'h0, MCEC_REQ_WRITE = 2'h1} mcec_kind_t;
   // device checker states, gray along idle->check->answer
   typedef enum logic [1:0] {MCEC_IDLE = 2'b00, MCEC_CHECK = 2'b01, MCEC_ANSWER = 2'b11}
      mcec_state_t;
   // true for opcodes that address a single axis
   function automatic logic mcec_single_axis(input logic [3:0] op);
      mcec_single_axis = (op == OP_X_AXIS_START) || (op == OP_Y_AXIS_START) ||
         (op == OP_MANUAL_JOG) || (op == OP_ORIGIN_SEARCH);
   endfunction : mcec_single_axis
   // required operand count for each opcode
   function automatic logic [2:0] mcec_opnd_need(input logic [3:0] op);
      case (op)
         OP_ERROR_RESET: mcec_opnd_need = 3'h0;
         OP_STOP: mcec_opnd_need = 3'h1;
         OP_INTERP_START: mcec_opnd_need = 3'h1;
         default: mcec_opnd_need = 3'h2;
      endcase
   endfunction : mcec_opnd_need
endpackage : mcec_pkg

/* File: hw/mcec_link_if.sv */
// link between host controller and positioning unit checker
`timescale 1ns/1ps
interface mcec_link_if;
   logic req_valid;
   logic req_ready;
   logic [1:0] req_kind;
   logic [3:0] cmd_op;
   logic [2:0] cmd_opnd_cnt;
   logic [7:0] cmd_opnd;
   logic cmd_opnd_fmt_ok;
   logic [15:0] wr_addr;
   logic [7:0] wr_words;
   logic [15:0] wr_len;
   logic wr_data_ok;
   logic wr_fmt_ok;
   logic ack_valid;
   logic [7:0] ack_code;
   logic [7:0] status_code;
   logic err_latched;
   modport unit (input req_valid, req_kind, cmd_op, cmd_opnd_cnt, cmd_opnd,
      cmd_opnd_fmt_ok, wr_addr, wr_words, wr_len, wr_data_ok, wr_fmt_ok,
      output req_ready, ack_valid, ack_code, status_code, err_latched);
   modport host (output req_valid, req_kind, cmd_op, cmd_opnd_cnt, cmd_opnd,
      cmd_opnd_fmt_ok, wr_addr, wr_words, wr_len, wr_data_ok, wr_fmt_ok,
      input req_ready, ack_valid, ack_code, status_code, err_latched);
endinterface : mcec_link_if

/* File: hw/mcec_serial_mon.sv */
// serial peripheral link monitor, reports line faults as error codes
`timescale 1ns/1ps
module mcec_serial_mon (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   // raw fault flags from the serial receiver pins
   input wire logic i_parity_fail,
   input wire logic i_frame_fail,
   input wire logic i_overrun,
   // reported fault, high for as long as a synchronized fault flag stands, with code
   output logic o_fault,
   output logic [7:0] o_code
);
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic fault;
      logic [7:0] code;
   } mcec_ser_t;
   mcec_ser_t q, d;
   // two-stage sync then priority encode of the faults
   always_comb
   begin
      d = q;
      d.s1 = {i_overrun, i_frame_fail, i_parity_fail};
      d.s2 = q.s1;
      d.fault = |q.s2;
      if (q.s2[0])
         d.code = mcec_pkg::ERR_PARITY;
      else if (q.s2[1])
         d.code = mcec_pkg::ERR_FRAMING;
      else if (q.s2[2])
         d.code = mcec_pkg::ERR_OVERRUN;
      else
         d.code = mcec_pkg::ERR_NONE;
   end
   // state register
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
         q <= '0;
      else if (i_ce)
         q <= d;
   end
   assign o_fault = q.fault;
   assign o_code = q.code;
endmodule : mcec_serial_mon

/* File: hw/mcec_host.sv */
// host controller end: issues commands and writes, waits for the answer
`timescale 1ns/1ps
module mcec_host (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   // user request
   input wire logic i_go,
   input wire logic i_is_write,
   input wire logic [3:0] i_op,
   input wire logic [2:0] i_opnd_cnt,
   input wire logic [7:0] i_opnd,
   input wire logic i_opnd_fmt_ok,
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_words,
   input wire logic [15:0] i_len,
   input wire logic i_data_ok,
   input wire logic i_fmt_ok,
   input wire logic i_axes_stopped,
   input wire logic i_origin_known,
   // link to unit
   mcec_link_if.host link,
   // user answer
   output logic o_busy,
   output logic o_done,
   output logic [7:0] o_code,
   output logic o_refused
);
   typedef struct packed {
      logic busy;
      logic sent;
      logic done;
      logic refused;
      logic [7:0] code;
      logic is_write;
      logic [3:0] op;
      logic [2:0] cnt;
      logic [7:0] opnd;
      logic ofmt;
      logic [15:0] addr;
      logic [7:0] words;
      logic [15:0] len;
      logic dok;
      logic fok;
   } mcec_host_t;
   mcec_host_t q, d;
   logic allowed;
   // host-side guards: cap word count, write only when stopped, position start only after origin
   assign allowed = i_is_write ? (i_axes_stopped && i_words <= {1'b0, mcec_pkg::WR_MAX_WORDS})
      : (i_op != mcec_pkg::OP_POSITION_START || i_origin_known);
   // request issue and answer capture
   always_comb
   begin
      d = q;
      d.done = 1'b0;
      d.refused = 1'b0;
      if (!q.busy && i_go)
      begin
         if (allowed)
         begin
            d.busy = 1'b1;
            d.sent = 1'b0;
            d.is_write = i_is_write;
            d.op = i_op;
            d.cnt = i_opnd_cnt;
            d.opnd = i_opnd;
            d.ofmt = i_opnd_fmt_ok;
            d.addr = i_addr;
            d.words = i_words;
            d.len = i_len;
            d.dok = i_data_ok;
            d.fok = i_fmt_ok;
         end
         else
            d.refused = 1'b1;
      end
      else if (q.busy && !q.sent && link.req_ready)
         d.sent = 1'b1;
      else if (q.busy && q.sent && link.ack_valid)
      begin
         d.busy = 1'b0;
         d.done = 1'b1;
         d.code = link.ack_code;
      end
   end
   // state register
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
         q <= '0;
      else if (i_ce)
         q <= d;
   end
   assign link.req_valid = q.busy && !q.sent;
   assign link.req_kind = q.is_write ? mcec_pkg::MCEC_REQ_WRITE : mcec_pkg::MCEC_REQ_CMD;
   assign link.cmd_op = q.op;
   assign link.cmd_opnd_cnt = q.cnt;
   assign link.cmd_opnd = q.opnd;
   assign link.cmd_opnd_fmt_ok = q.ofmt;
   assign link.wr_addr = q.addr;
   assign link.wr_words = q.words;
   assign link.wr_len = q.len;
   assign link.wr_data_ok = q.dok;
   assign link.wr_fmt_ok = q.fok;
   assign o_busy = q.busy;
   assign o_done = q.done;
   assign o_code = q.code;
   assign o_refused = q.refused;
endmodule : mcec_host

/* File: testbench/mcec_link_assertions.sv */
// concurrent checks on the link between the host end and the unit end
`timescale 1ns/1ps
module mcec_link_assertions (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // request fields
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic [1:0] req_kind,
   input wire logic [3:0] cmd_op,
   input wire logic [2:0] cmd_opnd_cnt,
   input wire logic [7:0] cmd_opnd,
   input wire logic cmd_opnd_fmt_ok,
   // answer fields
   input wire logic ack_valid,
   input wire logic [7:0] ack_code,
   input wire logic [7:0] status_code,
   input wire logic err_latched
);
   logic take;
   logic cmd;
   logic op_ok;
   logic cnt_ok;
   logic opnd_ok;
   // qualifiers of a taken command
   assign take = req_valid && req_ready;
   assign cmd = take && (req_kind == 2'h0);
   assign op_ok = (cmd_op != 4'h0) && (cmd_op <= 4'h8);
   assign cnt_ok = cmd_opnd_cnt == ((cmd_op == 4'h7) ? 3'h0 :
      ((cmd_op == 4'h4) || (cmd_op == 4'h8)) ? 3'h1 : 3'h2);
   assign opnd_ok = (cmd_op == 4'h7) || (cmd_opnd <= 8'h63);
   // one clock domain for all checks
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);
   // answer timing, command code and error latch checks
   a_ack_two_late: assert property (take |-> ##2 ack_valid)
      else $error("answer not two cycles after take");
   a_busy_after_take: assert property (take |=> !req_ready [*2])
      else $error("ready during check");
   a_ack_has_cause: assert property (ack_valid |-> $past(take, 2))
      else $error("answer without request");
   a_ack_one_cycle: assert property (ack_valid |=> !ack_valid)
      else $error("answer longer than a cycle");
   a_code_stands: assert property (!ack_valid |-> $stable(ack_code))
      else $error("answer code changed without answer");
   a_undef_opcode: assert property (cmd && !op_ok |-> ##2 ack_code == mcec_pkg::ERR_OPCODE)
      else $error("undefined opcode not coded");
   a_opnd_count: assert property (cmd && op_ok && !cnt_ok |->
      ##2 ack_code == mcec_pkg::ERR_OPND_COUNT)
      else $error("operand count not coded");
   a_opnd_undef: assert property (cmd && op_ok && cnt_ok && !opnd_ok |->
      ##2 ack_code == mcec_pkg::ERR_OPND_UNDEF)
      else $error("undefined operand not coded");
   a_opnd_format: assert property (cmd && op_ok && cnt_ok && opnd_ok && cmd_op != 4'h7 &&
      !cmd_opnd_fmt_ok |-> ##2 ack_code == mcec_pkg::ERR_OPND_FMT)
      else $error("operand format not coded");
   a_error_latched: assert property (ack_valid && ack_code != 8'h00 |->
      err_latched && status_code == ack_code)
      else $error("error code not latched");
   a_reset_clears: assert property (cmd && cmd_op == 4'h7 && cmd_opnd_cnt == 3'h0 |->
      ##2 ack_valid && ack_code == 8'h00 ##[0:1] !err_latched)
      else $error("error reset did not clear");
endmodule : mcec_link_assertions

/* File: testbench/tb.sv */
// self-checking bench joining host end and unit end over the link
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
   $display("[FAIL] t=%0t got %0h exp %0h", $time, a, b); end end
module tb;
   logic i_clk, i_rst_b, ce, go, isw, ofmt, dok, fok, stp, okn, busy, done, refd;
   logic xm, ym, ib, os, sz, so, bi, bd, as, ae, pf, ff, ov, ex, wx;
   logic [3:0] op, eop;
   logic [2:0] cnt;
   logic [7:0] opnd, words, code;
   logic [15:0] addr, len;
   int n_fail = 0;
   int checks = 0;
   int cyc = 0;
   mcec_link_if mcec_link_if_inst ();
   mcec_host mcec_host_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(ce), .i_go(go),
      .i_is_write(isw), .i_op(op), .i_opnd_cnt(cnt), .i_opnd(opnd), .i_opnd_fmt_ok(ofmt),
      .i_addr(addr), .i_words(words), .i_len(len), .i_data_ok(dok), .i_fmt_ok(fok),
      .i_axes_stopped(stp), .i_origin_known(okn), .link(mcec_link_if_inst.host),
      .o_busy(busy), .o_done(done), .o_code(code), .o_refused(refd));
   mcec_unit mcec_unit_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(ce),
      .link(mcec_link_if_inst.unit), .i_x_moving(xm), .i_y_moving(ym), .i_interp_busy(ib),
      .i_origin_set(os), .i_speed_zero(sz), .i_stroke_over(so), .i_blk_is_interp(bi),
      .i_blk_axis_dis(bd), .i_arc_same_end(as), .i_arc_no_end(ae), .i_ser_parity_fail(pf),
      .i_ser_frame_fail(ff), .i_ser_overrun(ov), .o_exec(ex), .o_exec_op(eop),
      .o_write_exec(wx));
   mcec_link_assertions chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
      .req_valid(mcec_link_if_inst.req_valid), .req_ready(mcec_link_if_inst.req_ready),
      .req_kind(mcec_link_if_inst.req_kind), .cmd_op(mcec_link_if_inst.cmd_op),
      .cmd_opnd_cnt(mcec_link_if_inst.cmd_opnd_cnt), .cmd_opnd(mcec_link_if_inst.cmd_opnd),
      .cmd_opnd_fmt_ok(mcec_link_if_inst.cmd_opnd_fmt_ok),
      .ack_valid(mcec_link_if_inst.ack_valid), .ack_code(mcec_link_if_inst.ack_code),
      .status_code(mcec_link_if_inst.status_code),
      .err_latched(mcec_link_if_inst.err_latched));
   // 50 ns clock
   initial
   begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   // hang guard
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         final_report();
      end
   end
   // counts and verdict
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report
   // a plain accepted position start with every condition good
   task automatic dflt();
      {go, isw, xm, ym, ib, sz, so, bd, as, ae, pf, ff, ov} = '0;
      {ofmt, dok, fok, stp, okn, os, bi} = '1;
      op = 4'h1;
      cnt = 3'h2;
      opnd = 8'h10;
      addr = 16'h0010;
      words = 8'h04;
      len = 16'h0004;
   endtask : dflt
   // one request through the host, answer and execution judged
   task automatic do_req(input logic [7:0] exp, input logic rf);
      logic fin;
      logic run;
      fin = 1'b0;
      run = 1'b0;
      @(posedge i_clk) #2 go = 1'b1;
      for (int n = 0; n < 20 && !fin; n++)
      begin
         // go stands one edge; a refusal pulse is visible right after that edge
         @(posedge i_clk) #2 go = 1'b0;
         if (ex === 1'b1 || wx === 1'b1) run = 1'b1;
         if (ex === 1'b1) `CHK(eop, op)
         fin = (done === 1'b1) || (refd === 1'b1);
      end
      `CHK(fin, 1'b1)
      `CHK(refd, rf)
      `CHK(busy, 1'b0)
      if (!rf) `CHK(code, exp)
      // an error reset is handled inside the unit and starts nothing
      `CHK(run, (exp == 8'h00) && !rf && (isw || op != mcec_pkg::OP_ERROR_RESET))
   endtask : do_req
   // every opcode value, defined ones accepted
   task automatic t_ops();
      dflt();
      for (int i = 0; i < 16; i++)
      begin
         op = 4'(i);
         cnt = (i == 7) ? 3'h0 : (i == 4 || i == 8) ? 3'h1 : 3'h2;
         do_req((i == 0 || i > 8) ? mcec_pkg::ERR_OPCODE : 8'h00, 1'b0);
         if (i != 7 && i > 0 && i < 9) `CHK(eop, op)
      end
      $display("test ops done");
   endtask : t_ops
   // operand count, value boundary and format
   task automatic t_opnd();
      dflt();
      cnt = 3'h1;
      do_req(mcec_pkg::ERR_OPND_COUNT, 1'b0);
      cnt = 3'h2;
      opnd = 8'h64;
      do_req(mcec_pkg::ERR_OPND_UNDEF, 1'b0);
      opnd = 8'h63;
      do_req(8'h00, 1'b0);
      ofmt = 1'b0;
      do_req(mcec_pkg::ERR_OPND_FMT, 1'b0);
      $display("test operands done");
   endtask : t_opnd
   // axis state, block data, stroke, speed and origin
   task automatic t_state();
      dflt();
      xm = 1'b1;
      do_req(mcec_pkg::ERR_TIMING, 1'b0);
      op = 4'h8;
      cnt = 3'h1;
      do_req(8'h00, 1'b0);
      dflt();
      ib = 1'b1;
      op = 4'h2;
      do_req(mcec_pkg::ERR_INTERP_BUSY, 1'b0);
      dflt();
      op = 4'h4;
      cnt = 3'h1;
      bi = 1'b0;
      do_req(mcec_pkg::ERR_NOT_INTERP, 1'b0);
      {bi, bd} = 2'b11;
      do_req(mcec_pkg::ERR_AXIS_DIS, 1'b0);
      {bd, as} = 2'b01;
      do_req(mcec_pkg::ERR_ARC_SAME, 1'b0);
      {as, ae} = 2'b01;
      do_req(mcec_pkg::ERR_ARC_NOEND, 1'b0);
      {ae, so} = 2'b01;
      do_req(mcec_pkg::ERR_STROKE, 1'b0);
      op = 4'h3;
      cnt = 3'h2;
      do_req(mcec_pkg::ERR_STROKE, 1'b0);
      so = 1'b0;
      sz = 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         op = (i == 0) ? 4'h1 : (i == 1) ? 4'h5 : 4'h6;
         do_req(mcec_pkg::ERR_SPEED0, 1'b0);
      end
      dflt();
      os = 1'b0;
      do_req(mcec_pkg::ERR_NO_ORIGIN, 1'b0);
      okn = 1'b0;
      do_req(8'h00, 1'b1);
      $display("test state done");
   endtask : t_state
   // host data writes: address, length, values, motion, word count
   task automatic t_write();
      dflt();
      isw = 1'b1;
      do_req(8'h00, 1'b0);
      addr = 16'h0400;
      do_req(mcec_pkg::ERR_WR_ADDR, 1'b0);
      addr = 16'h03FF;
      do_req(8'h00, 1'b0);
      len = 16'h0000;
      do_req(mcec_pkg::ERR_WR_LEN, 1'b0);
      len = 16'h0005;
      do_req(mcec_pkg::ERR_WR_LEN, 1'b0);
      len = 16'h0004;
      dok = 1'b0;
      do_req(mcec_pkg::ERR_WR_VALUE, 1'b0);
      {dok, fok} = 2'b10;
      do_req(mcec_pkg::ERR_WR_FMT, 1'b0);
      fok = 1'b1;
      words = 8'h80;
      do_req(8'h00, 1'b1);
      words = 8'h7F;
      do_req(8'h00, 1'b0);
      stp = 1'b0;
      do_req(8'h00, 1'b1);
      {stp, ym} = 2'b11;
      do_req(mcec_pkg::ERR_WR_MOVING, 1'b0);
      $display("test write done");
   endtask : t_write
   // latched code survives good traffic until error reset
   task automatic t_latch();
      dflt();
      op = 4'h0;
      do_req(mcec_pkg::ERR_OPCODE, 1'b0);
      op = 4'h1;
      do_req(8'h00, 1'b0);
      `CHK(mcec_link_if_inst.status_code, mcec_pkg::ERR_OPCODE)
      `CHK(mcec_link_if_inst.err_latched, 1'b1)
      op = 4'h7;
      cnt = 3'h1;
      do_req(mcec_pkg::ERR_OPND_COUNT, 1'b0);
      cnt = 3'h0;
      do_req(8'h00, 1'b0);
      `CHK(mcec_link_if_inst.status_code, 8'h00)
      `CHK(mcec_link_if_inst.err_latched, 1'b0)
      $display("test latch done");
   endtask : t_latch
   // serial faults with priority, each cleared by error reset
   task automatic t_serial();
      logic [7:0] exp;
      dflt();
      for (int k = 0; k < 3; k++)
      begin
         exp = (k == 0) ? mcec_pkg::ERR_PARITY : (k == 1) ? mcec_pkg::ERR_FRAMING :
            mcec_pkg::ERR_OVERRUN;
         @(posedge i_clk) #2 {pf, ff, ov} = (k == 0) ? 3'b111 : (k == 1) ? 3'b011 : 3'b001;
         repeat (4) @(posedge i_clk);
         #2 {pf, ff, ov} = 3'b000;
         repeat (6) @(posedge i_clk);
         #2 `CHK(mcec_link_if_inst.status_code, exp)
         `CHK(mcec_link_if_inst.err_latched, 1'b1)
         op = 4'h7;
         cnt = 3'h0;
         do_req(8'h00, 1'b0);
         `CHK(mcec_link_if_inst.status_code, 8'h00)
      end
      $display("test serial done");
   endtask : t_serial
   // reset, then the scenarios
   initial
   begin
      ce = 1'b1;
      i_rst_b = 1'b0;
      dflt();
      repeat (20) @(posedge i_clk);
      #2 i_rst_b = 1'b1;
      t_ops();
      t_opnd();
      t_state();
      t_write();
      t_latch();
      t_serial();
      final_report();
   end
endmodule : tb
